/* logic/ctmc_pkg.sv */
/*
  shared constants, types and register map of the transceiver mode control.
  assumes a single 250 MHz clock and a classic wishbone register bus.
*/
package ctmc_pkg;

  // --------------------------------------------------------------
  // clock and timing
  // --------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned T_INACTIVE_US = 1000;
  localparam int unsigned T_UV_US = 300;
  localparam int unsigned GO_TO_SLEEP_TIME_US = 20;
  localparam int unsigned T_MODE_HOLD_NS = 1000;
  localparam int unsigned SWE_CYCLES = T_INACTIVE_US * CLK_MHZ;
  localparam int unsigned UV_CYCLES = T_UV_US * CLK_MHZ;
  localparam int unsigned GTS_CYCLES = GO_TO_SLEEP_TIME_US * CLK_MHZ;
  localparam int unsigned HOLD_CYCLES = (T_MODE_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TMR_W = 32;

  // --------------------------------------------------------------
  // register map
  // --------------------------------------------------------------
  localparam logic [3:0] ADR_MODE_STATUS = 4'h0;
  localparam logic [3:0] ADR_IRQ_STATUS = 4'h4;
  localparam logic [3:0] ADR_IRQ_MASK = 4'h8;
  localparam int unsigned EVT_W = 4;
  localparam int unsigned EVT_MODE = 0;
  localparam int unsigned EVT_SWE = 1;
  localparam int unsigned EVT_UV = 2;
  localparam int unsigned EVT_WAKE = 3;
  localparam logic [EVT_W-1:0] MASK_RST = 4'h0;

  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_OFF = 3'b000,
    MODE_NORMAL = 3'b001,
    MODE_SILENT = 3'b010,
    MODE_STANDBY = 3'b011,
    MODE_GOSLEEP = 3'b100,
    MODE_SLEEP = 3'b101
  } ctmc_mode_e;

  typedef struct packed {
    logic en;
    logic standby_select_n;
    logic inhibit_mask_input;
    logic vcc_above_rise;
    logic vcc_below_fall;
    logic vio_above_rise;
    logic vio_below_fall;
    logic vsup_uv;
    logic over_temp;
    logic wake_event;
    logic bus_rx;
  } ctmc_pins_s;

  typedef struct packed {
    logic tx_enable;
    logic rx_enable;
    logic lp_monitor;
    logic rxd;
    logic inhibit_supply_output;
    logic fault_indicator_n;
  } ctmc_out_s;

  localparam ctmc_out_s OUT_RST = 6'b000101;

endpackage : ctmc_pkg

/* logic/ctmc_sync.sv */
/*
  two-stage synchroniser for a bundle of asynchronous pin levels.
  assumes inputs are quasi-static levels, not pulses shorter than a clock.
*/
`timescale 1ns/1ns
module ctmc_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  // --------------------------------------------------------------
  // two flops
  // --------------------------------------------------------------
  always_comb begin
    next_meta = d_i;
    next_q = meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= next_meta;
      q_o <= next_q;
    end
  end

endmodule : ctmc_sync

/* logic/ctmc_timer.sv */
/*
  saturating cycle counter with a terminal count.
  assumes run and clear come from logic on the same clock.
*/
`timescale 1ns/1ns
module ctmc_timer
  import ctmc_pkg::*;
#(
  parameter int unsigned TERM = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic clear_i,
  output logic expired_o
);

  localparam logic [TMR_W-1:0] TERM_C = TMR_W'(TERM);

  logic [TMR_W-1:0] cnt;
  logic [TMR_W-1:0] next_cnt;

  // --------------------------------------------------------------
  // counter
  // --------------------------------------------------------------
  always_comb begin
    next_cnt = cnt;
    if (clear_i) begin
      next_cnt = '0;
    end else if (run_i && cnt < TERM_C) begin
      next_cnt = cnt + TMR_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign expired_o = (cnt >= TERM_C) && !clear_i;

endmodule : ctmc_timer

/* logic/ctmc_top.sv */
/*
  mode control of a CAN FD transceiver with a wishbone register slave.
  assumes supply comparators, wake detector and bus receiver deliver
  asynchronous levels on pins_i; the bus master is classic wishbone.
*/
`timescale 1ns/1ns

// Operation
// - six modes chosen from enable, standby-select, supplies and wakes; temperature only gates outputs.
// - undervoltage timers stay off until their supply first passes rising threshold.
// - enabled timer runs while supply is below falling threshold; expiry enters sleep.
// - fail-safe timer starts on standby entry, halts and resets on normal entry.
// - fail-safe keeps running into silent from standby, inactive from normal.
// - sleep from go-to-sleep or undervoltage exits on standby-select rise, enable picks mode.
// - pin exits from sleep only while io supply is above rising threshold.
// - after fail-safe sleep, with select high, enable rise gives normal, fall silent.
// - inhibit mask sampled only in silent, latched, lost only on battery undervoltage.
// - standby, go-to-sleep, sleep: driver off, low power monitor; standby rxd low on wake.
// - normal enables receiver, and driver unless over temperature; rxd follows the bus.
// - silent disables driver, receiver stays on.
// - enable high and select low waits in go-to-sleep until timer expires, then sleep.
// - standby shows a pending wake request as rxd low.
module ctmc_top
  import ctmc_pkg::*;
#(
  parameter int unsigned SWE_CNT = SWE_CYCLES,
  parameter int unsigned UV_CNT = UV_CYCLES,
  parameter int unsigned GTS_CNT = GTS_CYCLES,
  parameter int unsigned HOLD_CNT = HOLD_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire ctmc_pins_s pins_i,
  output ctmc_out_s out_o,
  output logic [2:0] mode_o,
  output logic irq_o
);

  // --------------------------------------------------------------
  // pin synchronisation
  // --------------------------------------------------------------
  ctmc_pins_s pins;
  logic en_q;
  logic stb_q;

  ctmc_sync #(.W($bits(ctmc_pins_s))) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(pins_i),
    .q_o(pins)
  );

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  ctmc_mode_e mode;
  ctmc_mode_e next_mode;
  logic swe_active;
  logic next_swe_active;
  logic swe_cause;
  logic next_swe_cause;
  logic armed;
  logic next_armed;
  logic hold_run;
  logic next_hold_run;
  logic wake_flag;
  logic next_wake_flag;
  logic inh_latch;
  logic next_inh_latch;
  logic vcc_en;
  logic next_vcc_en;
  logic vio_en;
  logic next_vio_en;
  logic next_en_q;
  logic next_stb_q;
  logic [EVT_W-1:0] evt;

  logic swe_exp;
  logic uvcc_exp;
  logic uvio_exp;
  logic gts_exp;
  logic hold_exp;
  logic uvcc_run;
  logic uvio_run;
  logic en_rise;
  logic en_fall;
  logic stb_rise;
  logic in_sleep;

  // --------------------------------------------------------------
  // timers
  // --------------------------------------------------------------
  assign uvcc_run = vcc_en && pins.vcc_below_fall;
  assign uvio_run = vio_en && pins.vio_below_fall;
  assign in_sleep = (mode == MODE_SLEEP);

  ctmc_timer #(.TERM(SWE_CNT)) u_swe (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(swe_active),
    .clear_i(!swe_active),
    .expired_o(swe_exp)
  );

  ctmc_timer #(.TERM(UV_CNT)) u_uvcc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(uvcc_run),
    .clear_i(!uvcc_run),
    .expired_o(uvcc_exp)
  );

  ctmc_timer #(.TERM(UV_CNT)) u_uvio (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(uvio_run),
    .clear_i(!uvio_run),
    .expired_o(uvio_exp)
  );

  ctmc_timer #(.TERM(GTS_CNT)) u_gts (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(mode == MODE_GOSLEEP),
    .clear_i(mode != MODE_GOSLEEP),
    .expired_o(gts_exp)
  );

  ctmc_timer #(.TERM(HOLD_CNT)) u_hold (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(hold_run),
    .clear_i(!hold_run),
    .expired_o(hold_exp)
  );

  // --------------------------------------------------------------
  // mode selection
  // --------------------------------------------------------------
  assign en_rise = pins.en && !en_q;
  assign en_fall = !pins.en && en_q;
  assign stb_rise = pins.standby_select_n && !stb_q;

  always_comb begin
    next_mode = mode;
    next_swe_cause = swe_cause;
    next_en_q = pins.en;
    next_stb_q = pins.standby_select_n;
    evt = '0;
    case (mode)
      MODE_OFF: begin
        next_mode = MODE_STANDBY;
      end
      MODE_NORMAL, MODE_SILENT, MODE_STANDBY, MODE_GOSLEEP: begin
        case ({pins.en, pins.standby_select_n})
          2'b11: next_mode = MODE_NORMAL;
          2'b01: next_mode = MODE_SILENT;
          2'b10: next_mode = MODE_GOSLEEP;
          default: next_mode = MODE_STANDBY;
        endcase
        if (mode == MODE_STANDBY && wake_flag && next_mode == MODE_GOSLEEP) begin
          next_mode = MODE_STANDBY;
        end
        if (pins.vio_below_fall && next_mode != MODE_GOSLEEP) begin
          next_mode = MODE_STANDBY;
        end
        if (mode == MODE_GOSLEEP && gts_exp) begin
          next_mode = MODE_SLEEP;
          next_swe_cause = 1'b0;
        end
        if (swe_exp && (mode == MODE_STANDBY || mode == MODE_SILENT)) begin
          next_mode = MODE_SLEEP;
          next_swe_cause = 1'b1;
          evt[EVT_SWE] = 1'b1;
        end
        if (uvcc_exp || uvio_exp) begin
          next_mode = MODE_SLEEP;
          next_swe_cause = 1'b0;
          evt[EVT_UV] = 1'b1;
        end
      end
      MODE_SLEEP: begin
        if (pins.wake_event) begin
          next_mode = MODE_STANDBY;
        end else if (pins.vio_above_rise) begin
          if (!swe_cause) begin
            if (stb_rise) begin
              next_mode = pins.en ? MODE_NORMAL : MODE_SILENT;
            end
          end else if (armed && !hold_run && pins.standby_select_n) begin
            if (en_rise) begin
              next_mode = MODE_NORMAL;
            end else if (en_fall) begin
              next_mode = MODE_SILENT;
            end
          end
        end
      end
      default: begin
        next_mode = MODE_OFF;
      end
    endcase
    if (pins.vsup_uv) begin
      next_mode = MODE_OFF;
    end
    evt[EVT_MODE] = (next_mode != mode);
    evt[EVT_WAKE] = pins.wake_event && (mode == MODE_STANDBY || in_sleep);
  end

  // --------------------------------------------------------------
  // flags and sleep exit sequencing
  // --------------------------------------------------------------
  always_comb begin
    next_swe_active = swe_active;
    if (next_mode == MODE_STANDBY) begin
      next_swe_active = 1'b1;
    end else if (next_mode != MODE_SILENT || mode == MODE_NORMAL) begin
      next_swe_active = 1'b0;
    end
    next_armed = armed;
    next_hold_run = hold_run;
    if (!in_sleep) begin
      next_armed = !pins.standby_select_n;
      next_hold_run = 1'b0;
    end else if (!armed && !pins.standby_select_n && (en_rise || en_fall)) begin
      next_armed = 1'b1;
      next_hold_run = 1'b1;
    end else if (hold_exp) begin
      next_hold_run = 1'b0;
    end
    next_wake_flag = wake_flag;
    if (next_mode == MODE_NORMAL) begin
      next_wake_flag = 1'b0;
    end
    if (evt[EVT_WAKE]) begin
      next_wake_flag = 1'b1;
    end
    next_inh_latch = inh_latch;
    if (pins.vsup_uv) begin
      next_inh_latch = 1'b0;
    end else if (mode == MODE_SILENT) begin
      next_inh_latch = pins.inhibit_mask_input;
    end
    next_vcc_en = vcc_en || pins.vcc_above_rise;
    next_vio_en = vio_en || pins.vio_above_rise;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= MODE_OFF;
      swe_active <= 1'b0;
      swe_cause <= 1'b0;
      armed <= 1'b0;
      hold_run <= 1'b0;
      wake_flag <= 1'b0;
      inh_latch <= 1'b0;
      vcc_en <= 1'b0;
      vio_en <= 1'b0;
      en_q <= 1'b0;
      stb_q <= 1'b0;
    end else begin
      mode <= next_mode;
      swe_active <= next_swe_active;
      swe_cause <= next_swe_cause;
      armed <= next_armed;
      hold_run <= next_hold_run;
      wake_flag <= next_wake_flag;
      inh_latch <= next_inh_latch;
      vcc_en <= next_vcc_en;
      vio_en <= next_vio_en;
      en_q <= next_en_q;
      stb_q <= next_stb_q;
    end
  end

  // --------------------------------------------------------------
  // pin outputs
  // --------------------------------------------------------------
  ctmc_out_s next_out;

  always_comb begin
    next_out = OUT_RST;
    next_out.fault_indicator_n = !pins.over_temp;
    next_out.inhibit_supply_output = 1'b1;
    case (mode)
      MODE_NORMAL: begin
        next_out.tx_enable = !pins.over_temp;
        next_out.rx_enable = 1'b1;
        next_out.rxd = pins.bus_rx;
      end
      MODE_SILENT: begin
        next_out.rx_enable = 1'b1;
        next_out.rxd = pins.bus_rx;
      end
      MODE_STANDBY: begin
        next_out.lp_monitor = 1'b1;
        next_out.rxd = !wake_flag;
        next_out.inhibit_supply_output = !inh_latch;
      end
      MODE_GOSLEEP: begin
        next_out.lp_monitor = 1'b1;
      end
      MODE_SLEEP: begin
        next_out.lp_monitor = 1'b1;
        next_out.inhibit_supply_output = 1'b0;
      end
      default: begin
        next_out.inhibit_supply_output = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------
  // wishbone slave and interrupts
  // --------------------------------------------------------------
  logic [EVT_W-1:0] irq_status;
  logic [EVT_W-1:0] next_irq_status;
  logic [EVT_W-1:0] irq_mask;
  logic [EVT_W-1:0] next_irq_mask;
  logic [31:0] next_dat;
  logic next_ack;
  logic req;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_comb begin
    next_ack = req;
    next_dat = '0;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        ADR_MODE_STATUS: next_dat = {24'h0, inh_latch, wake_flag, swe_active, 2'b00, mode};
        ADR_IRQ_STATUS: begin
          next_dat = {28'h0, irq_status};
          next_irq_status = '0;
        end
        ADR_IRQ_MASK: next_dat = {28'h0, irq_mask};
        default: next_dat = '0;
      endcase
    end
    if (req && wb_we_i && wb_adr_i == ADR_IRQ_MASK && wb_sel_i[0]) begin
      next_irq_mask = wb_dat_i[EVT_W-1:0];
    end
    next_irq_status = next_irq_status | evt;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= '0;
      irq_mask <= MASK_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      out_o <= OUT_RST;
      mode_o <= MODE_OFF;
      irq_o <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
      out_o <= next_out;
      mode_o <= mode;
      irq_o <= |(next_irq_status & next_irq_mask);
    end
  end

endmodule : ctmc_top

/* bench/ctmc_properties.sv */
/*
  assertions on the ports of the mode control top.
  assumes one clock and small timer counts handed on by bind.
*/
`timescale 1ns/1ns
module ctmc_properties
  import ctmc_pkg::*;
#(
  parameter int unsigned SWE_CNT = SWE_CYCLES,
  parameter int unsigned GTS_CNT = GTS_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire ctmc_pins_s pins_i,
  input wire ctmc_out_s out_o,
  input wire logic [2:0] mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // --------
  // dwell counters
  // --------
  logic [31:0] sby_cnt, next_sby_cnt, gts_cnt, next_gts_cnt;
  always_comb begin
    next_sby_cnt = (rst_i || mode_o != MODE_STANDBY) ? 32'h0 : sby_cnt + 32'h1;
    next_gts_cnt = (rst_i || mode_o != MODE_GOSLEEP) ? 32'h0 : gts_cnt + 32'h1;
  end
  always_ff @(posedge clk_i) begin
    sby_cnt <= next_sby_cnt;
    gts_cnt <= next_gts_cnt;
  end
  // --------
  // properties
  // --------
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_in(logic [2:0] m);
    (mode_o == m)[*2];
  endsequence
  property p_ack_answer; s_req |=> wb_ack_o; endproperty
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_normal; s_in(MODE_NORMAL) |-> out_o.rx_enable && !out_o.lp_monitor; endproperty
  property p_silent; s_in(MODE_SILENT) |-> !out_o.tx_enable && out_o.rx_enable; endproperty
  property p_low_power;
    (mode_o inside {MODE_STANDBY, MODE_GOSLEEP, MODE_SLEEP})[*2]
      |-> !out_o.tx_enable && out_o.lp_monitor;
  endproperty
  property p_sleep_out; s_in(MODE_SLEEP) |-> !out_o.inhibit_supply_output && out_o.rxd; endproperty
  property p_vsup_off; pins_i.vsup_uv[*5] |-> mode_o == MODE_OFF; endproperty
  property p_standby_bound; sby_cnt <= SWE_CNT + 4; endproperty
  property p_gts_bound; gts_cnt <= GTS_CNT + 4; endproperty
  property p_sleep_vio;
    (mode_o == MODE_SLEEP && !pins_i.vio_above_rise)[*4]
      |=> !(mode_o inside {MODE_NORMAL, MODE_SILENT});
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("no ack after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_normal: assert property (p_normal) else $error("normal outputs wrong");
  a_silent: assert property (p_silent) else $error("silent outputs wrong");
  a_low_power: assert property (p_low_power) else $error("low power outputs wrong");
  a_sleep_out: assert property (p_sleep_out) else $error("sleep outputs wrong");
  a_vsup_off: assert property (p_vsup_off) else $error("no off on battery low");
  a_standby_bound: assert property (p_standby_bound) else $error("standby too long");
  a_gts_bound: assert property (p_gts_bound) else $error("go-to-sleep too long");
  a_sleep_vio: assert property (p_sleep_vio) else $error("sleep left without io");
endmodule : ctmc_properties

/* bench/ctmc_host_model.sv */
/*
  host controller model driving mode pins and supply levels.
  assumes the caller hands on the hold count of the device.
*/
`timescale 1ns/1ns
module ctmc_host_model
  import ctmc_pkg::*;
#(
  parameter int unsigned HOLD_CNT = 4
) (
  input wire logic clk_i,
  output ctmc_pins_s pins_o
);
  initial begin
    pins_o = '0;
    pins_o.vcc_below_fall = 1'b1;
    pins_o.vio_above_rise = 1'b1;
    pins_o.bus_rx = 1'b1;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : idle
  task automatic set_sel(input logic en, input logic stbn);
    @(posedge clk_i);
    pins_o.en <= en;
    pins_o.standby_select_n <= stbn;
    idle(6);
  endtask : set_sel
  // arm with select low, hold, raise select, final enable edge
  task automatic exit_safe();
    set_sel(!pins_o.en, 1'b0);
    idle(HOLD_CNT + 2);
    set_sel(pins_o.en, 1'b1);
    set_sel(!pins_o.en, 1'b1);
  endtask : exit_safe
endmodule : ctmc_host_model

/* bench/testbench.sv */
/*
  self-checking bench for the transceiver mode control.
  assumes small timer counts and the host model on the pin side.
*/
`timescale 1ns/1ns
module testbench
  import ctmc_pkg::*;
;
  localparam int unsigned SLEEP_WAKE_ERROR_TIMER = 40, UV = 20, GTS = 10, HOLD = 4;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] dat_w = 32'h0, dat_r, rd;
  logic ack, irq;
  logic [2:0] mode;
  ctmc_pins_s pins;
  ctmc_out_s out;
  int fail_count = 0, checks_done = 0;
  always #2 clk_i = ~clk_i;
  ctmc_top #(.SWE_CNT(SLEEP_WAKE_ERROR_TIMER), .UV_CNT(UV), .GTS_CNT(GTS), .HOLD_CNT(HOLD)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .pins_i(pins), .out_o(out), .mode_o(mode), .irq_o(irq));
  ctmc_host_model #(.HOLD_CNT(HOLD)) host (.clk_i(clk_i), .pins_o(pins));
  // --------
  // tasks
  // --------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    dat_w <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    check("ack", {31'h0, ack}, 32'h1);
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rdchk(input string name, input logic [3:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask : rdchk
  task automatic wait_mode(input ctmc_mode_e m, input int lim);
    int n;
    n = 0;
    while (mode !== m && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    check("mode", {29'h0, mode}, {29'h0, m});
  endtask : wait_mode
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  // --------
  // tests
  // --------
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_mode(MODE_STANDBY, 10);
    check("out", 32'(out), 32'h0f);
    host.idle(UV + 8);
    check("mode", {29'h0, mode}, 32'h3);
    host.pins_o.vcc_above_rise <= 1'b1;
    host.pins_o.vcc_below_fall <= 1'b0;
    host.set_sel(1'b1, 1'b1);
    wait_mode(MODE_NORMAL, 20);
    rdchk("mask", ADR_IRQ_MASK, 32'h0);
    wb(1'b1, ADR_IRQ_MASK, 32'hf);
    rdchk("mask", ADR_IRQ_MASK, 32'hf);
    wb(1'b1, 4'hc, 32'hff);
    rdchk("unmapped", 4'hc, 32'h0);
    check("out", 32'(out), 32'h37);
    host.pins_o.bus_rx <= 1'b0;
    host.idle(5);
    check("rxd", {31'h0, out.rxd}, 32'h0);
    host.pins_o.bus_rx <= 1'b1;
    host.pins_o.over_temp <= 1'b1;
    host.idle(5);
    check("out", 32'(out), 32'h16);
    host.pins_o.over_temp <= 1'b0;
    host.idle(5);
    check("out", 32'(out), 32'h37);
    check("irq", {31'h0, irq}, 32'h1);
    rdchk("status", ADR_IRQ_STATUS, 32'h1);
    host.idle(2);
    check("irq", {31'h0, irq}, 32'h0);
    $display("test normal done");
    host.set_sel(1'b0, 1'b1);
    wait_mode(MODE_SILENT, 20);
    check("out", 32'(out), 32'h17);
    host.pins_o.inhibit_mask_input <= 1'b1;
    host.idle(SLEEP_WAKE_ERROR_TIMER * 2);
    check("mode", {29'h0, mode}, 32'h2);
    rdchk("mode status", ADR_MODE_STATUS, 32'h82);
    host.set_sel(1'b0, 1'b0);
    wait_mode(MODE_STANDBY, 20);
    check("inh", {31'h0, out.inhibit_supply_output}, 32'h0);
    host.set_sel(1'b0, 1'b1);
    wait_mode(MODE_SLEEP, SLEEP_WAKE_ERROR_TIMER + 20);
    host.pins_o.inhibit_mask_input <= 1'b0;
    check("out", 32'(out), 32'h0d);
    rdchk("mode status", ADR_MODE_STATUS, 32'h85);
    rdchk("status", ADR_IRQ_STATUS, 32'h3);
    $display("test fail-safe done");
    host.pins_o.vio_above_rise <= 1'b0;
    host.exit_safe();
    host.idle(8);
    check("mode", {29'h0, mode}, 32'h5);
    host.pins_o.vio_above_rise <= 1'b1;
    host.exit_safe();
    wait_mode(MODE_SILENT, 20);
    host.set_sel(1'b1, 1'b0);
    check("out", 32'(out), 32'h0f);
    wait_mode(MODE_SLEEP, GTS + 20);
    check("inh", {31'h0, out.inhibit_supply_output}, 32'h0);
    host.set_sel(1'b1, 1'b1);
    wait_mode(MODE_NORMAL, 20);
    $display("test sleep exits done");
    wb(1'b1, ADR_IRQ_MASK, 32'h0);
    host.pins_o.vcc_below_fall <= 1'b1;
    wait_mode(MODE_SLEEP, UV + 20);
    host.pins_o.vcc_below_fall <= 1'b0;
    check("irq", {31'h0, irq}, 32'h0);
    rdchk("status", ADR_IRQ_STATUS, 32'h5);
    host.set_sel(1'b0, 1'b0);
    host.set_sel(1'b0, 1'b1);
    wait_mode(MODE_SILENT, 20);
    host.set_sel(1'b0, 1'b0);
    host.pins_o.vsup_uv <= 1'b1;
    wait_mode(MODE_OFF, 20);
    check("out", 32'(out), 32'h05);
    host.pins_o.vsup_uv <= 1'b0;
    wait_mode(MODE_STANDBY, 20);
    rdchk("mode status", ADR_MODE_STATUS, 32'h23);
    host.pins_o.wake_event <= 1'b1;
    host.idle(6);
    check("rxd", {31'h0, out.rxd}, 32'h0);
    host.pins_o.wake_event <= 1'b0;
    rdchk("status", ADR_IRQ_STATUS, 32'h9);
    $display("test supplies done");
    wrap_up();
  end
  initial begin
    #(4 * 20000);
    fail_count++;
    wrap_up();
  end
endmodule : testbench

bind ctmc_top ctmc_properties #(.SWE_CNT(SWE_CNT), .GTS_CNT(GTS_CNT)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .pins_i(pins_i), .out_o(out_o), .mode_o(mode_o));
